// ### rtl/ccd_pkg.sv
// Constants, field layouts, carrier structs and shared functions for the
// cache control and diagnostic access block. No surroundings assumed.
package ccd_pkg;
    localparam logic [7:0] IPR_CACHE_CONTROL = 8'h25;
    // Cache control register fields
    localparam int CC_DIAG = 0;
    localparam int CC_FLUSH = 1;
    localparam int CC_ENABLE = 2;
    localparam int CC_INVERT = 3;
    localparam int CC_ONE = 4;
    localparam int CC_UNUSED_W = 27;
    // Diagnostic window in I/O space
    localparam logic [31:0] DIAG_TAG_LO = 32'h2015_0000;
    localparam logic [31:0] DIAG_TAG_HI = 32'h2015_03ff;
    localparam logic [31:0] DIAG_DATA_LO = 32'h2015_0400;
    localparam logic [31:0] DIAG_DATA_HI = 32'h2015_07ff;
    localparam logic [31:0] DIAG_BANK_ENABLE_HIT_REG_LO = 32'h2015_0800;
    localparam logic [31:0] DIAG_BANK_ENABLE_HIT_REG_HI = 32'h2015_0fff;
    // Geometry
    localparam int NBANK = 8;
    localparam int NROW = 128;
    localparam int NLW = 256;
    localparam int ROW_LO = 3;
    localparam int LW_LO = 2;
    localparam int TAG_LO = 10;
    localparam int TAG_W = 19;
    localparam int CACHEABLE_BIT = 29;
    localparam int FILL_LAST_BIT = 2;
    localparam logic [2:0] REPL_RESET = 3'h0;
    localparam logic [2:0] REPL_LAST = 3'h5;
    // Bank enable/hit register layout
    localparam int BANK_ENABLE_HIT_REG_EN_LO = 0;
    localparam int BANK_ENABLE_HIT_REG_HIT_LO = 8;
    // Diagnostic tag word layout (tag itself sits at its address position)
    localparam int DT_VALID_BIT = 0;
    localparam int DT_TPAR_BIT = 1;
    localparam int DT_DPAR_LO = 4;

    typedef struct packed {
        logic par;
        logic valid;
        logic [TAG_W-1:0] tag;
    } ccd_tag_t;

    typedef struct packed {
        logic [3:0] par;
        logic [31:0] data;
    } ccd_word_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] num;
        logic [31:0] wdata;
    } ccd_ipr_req_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic dstream;
        logic [3:0] be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ccd_acc_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } ccd_fill_t;

    // Even parity on even byte lanes, odd parity on odd lanes
    function automatic logic [3:0] ccd_data_par(input logic [31:0] d);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 4; i++)
            p[i] = (^d[i*8 +: 8]) ^ ((i % 2) == 1);
        return p;
    endfunction : ccd_data_par

    // Odd parity over the tag field only
    function automatic logic ccd_tag_par(input logic [TAG_W-1:0] t);
        return ~(^t);
    endfunction : ccd_tag_par

    // Lowest-numbered set bit; bank 0 has the highest priority
    function automatic logic [2:0] ccd_first(input logic [NBANK-1:0] v);
        logic [2:0] r;
        r = '0;
        for (int i = NBANK - 1; i >= 0; i--)
            if (v[i])
                r = 3'(i);
        return r;
    endfunction : ccd_first
endpackage : ccd_pkg

// ### rtl/ccd_bank.sv
// One cache bank: tag, valid and parity per row, data longwords with parity.
// Assumes one tag and one data access per cycle chosen by the parent.
`timescale 1ns/100ps
module ccd_bank (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic [6:0] row_i,
    input wire logic tag_we_i,
    input wire ccd_pkg::ccd_tag_t tag_i,
    input wire logic [7:0] lw_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    output ccd_pkg::ccd_tag_t tag_o,
    output ccd_pkg::ccd_word_t word_o
);
    logic [ccd_pkg::TAG_W-1:0] tag_mem [ccd_pkg::NROW];
    logic tpar_mem [ccd_pkg::NROW];
    logic [ccd_pkg::NROW-1:0] valid;
    ccd_pkg::ccd_word_t data_mem [ccd_pkg::NLW];
    logic [31:0] merged;

    always_ff @(posedge clock_i)
    begin
        if (rst_i || flush_i)
            valid <= '0;
        else if (tag_we_i)
            valid[row_i] <= tag_i.valid;
    end

    always_ff @(posedge clock_i)
    begin
        if (tag_we_i)
        begin
            tag_mem[row_i] <= tag_i.tag;
            tpar_mem[row_i] <= tag_i.par;
        end
    end

    // Partial writes merge with the stored longword, parity is regenerated
    always_comb
    begin
        merged = data_mem[lw_i].data;
        for (int i = 0; i < 4; i++)
            if (be_i[i])
                merged[i*8 +: 8] = wdata_i[i*8 +: 8];
    end

    always_ff @(posedge clock_i)
    begin
        if (be_i != 4'h0)
            data_mem[lw_i] <= '{par: ccd_pkg::ccd_data_par(merged), data: merged};
    end

    assign tag_o = '{par: tpar_mem[row_i], valid: valid[row_i], tag: tag_mem[row_i]};
    assign word_o = data_mem[lw_i];
endmodule : ccd_bank

// ### rtl/ccd_ctrl.sv
// Cache control register, bank arrays, lookup/fill path and diagnostic
// I/O window. Assumes the processor presents one INTERNAL_PROC_REG access, one I/O access
// and one lookup per cycle on the same clock; fill longwords come in pairs.
`timescale 1ns/100ps
module ccd_ctrl (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire ccd_pkg::ccd_ipr_req_t ipr_i,
    output logic ipr_ack_o,
    output logic [31:0] ipr_rdata_o,
    input wire ccd_pkg::ccd_acc_t io_i,
    output logic io_pass_o,
    output logic io_ack_o,
    output logic [31:0] io_rdata_o,
    input wire ccd_pkg::ccd_acc_t lk_i,
    output logic lk_ready_o,
    output logic lk_done_o,
    output logic lk_hit_o,
    output logic [31:0] lk_rdata_o,
    output logic lk_tag_perr_o,
    output logic lk_data_perr_o,
    input wire ccd_pkg::ccd_fill_t fill_i,
    output logic [2:0] repl_ptr_o
);
    localparam int NB = ccd_pkg::NBANK;

    logic cache_enable;
    logic invert_data_parity;
    logic diag_window_on;
    logic [NB-1:0] bank_en;
    logic [NB-1:0] bank_hit;
    logic [2:0] repl;
    logic ipr_sel;
    logic flush_all_valid;
    logic in_tag;
    logic in_data;
    logic in_bank_enable_hit_reg;
    logic diag_go;
    logic fill_go;
    logic lk_go;
    logic [31:0] addr_sel;
    logic [31:0] wdata_sel;
    logic [NB-1:0] active_en;
    logic [NB-1:0] lookup_en;
    logic [NB-1:0] hit_vec;
    logic [NB-1:0] tag_we;
    logic [3:0] bank_be [NB];
    ccd_pkg::ccd_tag_t tag_in;
    ccd_pkg::ccd_tag_t tag_rd [NB];
    ccd_pkg::ccd_word_t word_rd [NB];
    logic [3:0] par_rd [NB];
    logic [2:0] diag_pick;
    logic [2:0] hit_pick;
    logic [31:0] next_io_rdata;

    assign ipr_sel = ipr_i.num == ccd_pkg::IPR_CACHE_CONTROL;
    assign flush_all_valid = ipr_i.wr && ipr_sel && ipr_i.wdata[ccd_pkg::CC_FLUSH];

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cache_enable <= 1'b0;
            invert_data_parity <= 1'b0;
            diag_window_on <= 1'b0;
        end
        else if (ipr_i.wr && ipr_sel)
        begin
            cache_enable <= ipr_i.wdata[ccd_pkg::CC_ENABLE];
            invert_data_parity <= ipr_i.wdata[ccd_pkg::CC_INVERT];
            diag_window_on <= ipr_i.wdata[ccd_pkg::CC_DIAG];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ipr_ack_o <= 1'b0;
            ipr_rdata_o <= '0;
        end
        else
        begin
            ipr_ack_o <= ipr_i.rd && ipr_sel;
            ipr_rdata_o <= '0;
            if (ipr_i.rd && ipr_sel)
            begin
                ipr_rdata_o[ccd_pkg::CC_ONE] <= 1'b1;
                ipr_rdata_o[ccd_pkg::CC_INVERT] <= invert_data_parity;
                ipr_rdata_o[ccd_pkg::CC_ENABLE] <= cache_enable;
                ipr_rdata_o[ccd_pkg::CC_DIAG] <= diag_window_on;
            end
        end
    end

    // Window decode; outside diagnostic mode the region goes out to the bus
    assign in_tag = io_i.addr >= ccd_pkg::DIAG_TAG_LO && io_i.addr <= ccd_pkg::DIAG_TAG_HI;
    assign in_data = io_i.addr >= ccd_pkg::DIAG_DATA_LO && io_i.addr <= ccd_pkg::DIAG_DATA_HI;
    assign in_bank_enable_hit_reg = io_i.addr >= ccd_pkg::DIAG_BANK_ENABLE_HIT_REG_LO && io_i.addr <= ccd_pkg::DIAG_BANK_ENABLE_HIT_REG_HI;
    assign fill_go = fill_i.valid && cache_enable;
    assign diag_go = io_i.req && diag_window_on && (in_tag || in_data || in_bank_enable_hit_reg) && !fill_go;
    assign io_pass_o = io_i.req && !(diag_window_on && (in_tag || in_data || in_bank_enable_hit_reg));
    assign lk_ready_o = !fill_go && !diag_go;
    assign lk_go = lk_i.req && lk_ready_o;

    assign active_en = bank_en & {NB{cache_enable | diag_window_on}};
    assign lookup_en = bank_en & {NB{cache_enable}};
    assign addr_sel = fill_go ? fill_i.addr : (diag_go ? io_i.addr : lk_i.addr);
    assign wdata_sel = fill_go ? fill_i.data : (diag_go ? io_i.wdata : lk_i.wdata);

    always_comb
    begin
        if (fill_go)
            tag_in = '{par: ccd_pkg::ccd_tag_par(fill_i.addr[ccd_pkg::TAG_LO +: ccd_pkg::TAG_W]), valid: 1'b1,
                       tag: fill_i.addr[ccd_pkg::TAG_LO +: ccd_pkg::TAG_W]};
        else
            tag_in = '{par: io_i.wdata[ccd_pkg::DT_TPAR_BIT], valid: io_i.wdata[ccd_pkg::DT_VALID_BIT],
                       tag: io_i.wdata[ccd_pkg::TAG_LO +: ccd_pkg::TAG_W]};
    end

    for (genvar b = 0; b < NB; b++)
    begin : g_bank
        assign par_rd[b] = word_rd[b].par ^ {4{invert_data_parity}};
        assign hit_vec[b] = lk_go && !lk_i.addr[ccd_pkg::CACHEABLE_BIT] && lookup_en[b] && tag_rd[b].valid
                            && tag_rd[b].tag == lk_i.addr[ccd_pkg::TAG_LO +: ccd_pkg::TAG_W];
        assign tag_we[b] = (fill_go && repl == 3'(b) && lookup_en[b])
                           || (diag_go && io_i.wr && in_tag && active_en[b]);
        always_comb
        begin
            if (fill_go)
                bank_be[b] = (repl == 3'(b) && lookup_en[b]) ? 4'hf : 4'h0;
            else if (diag_go && io_i.wr && in_data && active_en[b])
                bank_be[b] = io_i.be;
            else if (lk_go && lk_i.wr && hit_vec[b])
                bank_be[b] = lk_i.be;
            else
                bank_be[b] = 4'h0;
        end
        ccd_bank u_bank (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .flush_i(flush_all_valid),
            .row_i(addr_sel[ccd_pkg::ROW_LO +: 7]),
            .tag_we_i(tag_we[b]),
            .tag_i(tag_in),
            .lw_i(addr_sel[ccd_pkg::LW_LO +: 8]),
            .be_i(bank_be[b]),
            .wdata_i(wdata_sel),
            .tag_o(tag_rd[b]),
            .word_o(word_rd[b])
        );
    end

    assign diag_pick = ccd_pkg::ccd_first(active_en);
    assign hit_pick = ccd_pkg::ccd_first(hit_vec);

    always_comb
    begin
        next_io_rdata = '0;
        if (in_bank_enable_hit_reg)
        begin
            next_io_rdata[ccd_pkg::BANK_ENABLE_HIT_REG_EN_LO +: NB] = bank_en;
            next_io_rdata[ccd_pkg::BANK_ENABLE_HIT_REG_HIT_LO +: NB] = bank_hit;
        end
        else if (active_en != '0 && in_data)
            next_io_rdata = word_rd[diag_pick].data;
        else if (active_en != '0)
        begin
            next_io_rdata[ccd_pkg::TAG_LO +: ccd_pkg::TAG_W] = tag_rd[diag_pick].tag;
            next_io_rdata[ccd_pkg::DT_VALID_BIT] = tag_rd[diag_pick].valid;
            next_io_rdata[ccd_pkg::DT_TPAR_BIT] = tag_rd[diag_pick].par;
            next_io_rdata[ccd_pkg::DT_DPAR_LO +: 4] = par_rd[diag_pick];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            io_ack_o <= 1'b0;
            io_rdata_o <= '0;
        end
        else
        begin
            io_ack_o <= diag_go;
            io_rdata_o <= (diag_go && !io_i.wr) ? next_io_rdata : '0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            bank_en <= '0;
        else if (diag_go && io_i.wr && in_bank_enable_hit_reg && io_i.be[0])
            bank_en <= io_i.wdata[ccd_pkg::BANK_ENABLE_HIT_REG_EN_LO +: NB];
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            bank_hit <= '0;
        else if (lk_go && lk_i.dstream)
            bank_hit <= hit_vec;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i || !cache_enable)
            repl <= ccd_pkg::REPL_RESET;
        else if ((fill_go && fill_i.addr[ccd_pkg::FILL_LAST_BIT]) || (lk_go && hit_vec[repl]))
            repl <= (repl == ccd_pkg::REPL_LAST) ? ccd_pkg::REPL_RESET : repl + 3'h1;
    end
    assign repl_ptr_o = repl;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            lk_done_o <= 1'b0;
            lk_hit_o <= 1'b0;
            lk_rdata_o <= '0;
            lk_tag_perr_o <= 1'b0;
            lk_data_perr_o <= 1'b0;
        end
        else
        begin
            lk_done_o <= lk_go;
            lk_hit_o <= hit_vec != '0;
            lk_rdata_o <= (hit_vec != '0) ? word_rd[hit_pick].data : '0;
            lk_tag_perr_o <= hit_vec != '0
                             && ccd_pkg::ccd_tag_par(tag_rd[hit_pick].tag) != tag_rd[hit_pick].par;
            lk_data_perr_o <= hit_vec != '0 && !lk_i.wr
                              && ccd_pkg::ccd_data_par(word_rd[hit_pick].data) != par_rd[hit_pick];
        end
    end

    chk_ccr_upper_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        ipr_ack_o |-> ipr_rdata_o[31:5] == '0) else $error("control upper bits not zero");
    chk_ccr_one_bit: assert property (@(posedge clock_i) disable iff (rst_i)
        ipr_ack_o |-> ipr_rdata_o[ccd_pkg::CC_ONE] && !ipr_rdata_o[ccd_pkg::CC_FLUSH])
        else $error("control bit 4 or flush readback wrong");
    chk_enable_reset: assert property (@(posedge clock_i)
        rst_i |=> !cache_enable && !invert_data_parity) else $error("reset left enable set");
    chk_miss_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
        lk_go && !cache_enable |=> lk_done_o && !lk_hit_o && !lk_tag_perr_o && !lk_data_perr_o)
        else $error("hit or parity while disabled");
    chk_repl_held: assert property (@(posedge clock_i) disable iff (rst_i)
        !cache_enable |=> repl_ptr_o == ccd_pkg::REPL_RESET) else $error("pointer not zero");
    chk_window_pass: assert property (@(posedge clock_i) disable iff (rst_i)
        io_i.req && !diag_window_on |-> io_pass_o ##1 !io_ack_o) else $error("window claimed in normal mode");
    chk_bank_enable_hit_reg_read: assert property (@(posedge clock_i) disable iff (rst_i)
        diag_go && !io_i.wr && in_bank_enable_hit_reg |=> io_ack_o && io_rdata_o[7:0] == $past(bank_en))
        else $error("bank register read wrong");
    chk_banks_off: assert property (@(posedge clock_i) disable iff (rst_i)
        !cache_enable && !diag_window_on |-> tag_we == '0 && hit_vec == '0) else $error("bank active while off");
    chk_flush_valid: assert property (@(posedge clock_i) disable iff (rst_i)
        flush_all_valid |=> tag_rd[0].valid == 1'b0) else $error("flush left a valid bit");
    cov_flush: cover property (@(posedge clock_i) flush_all_valid);
    cov_diag_data_wr: cover property (@(posedge clock_i) diag_go && io_i.wr && in_data);
    cov_lookup_hit: cover property (@(posedge clock_i) lk_go ##1 lk_hit_o);
    cov_parity_err: cover property (@(posedge clock_i) lk_data_perr_o);
endmodule : ccd_ctrl

// ### test/test_cache_control_diag_access.sv
// Self-checking bench for the cache control register and diagnostic window.
// Assumes ccd_pkg and ccd_ctrl are compiled first; the bench drives all ports.
`timescale 1ns/100ps
module test_cache_control_diag_access;
    localparam logic [31:0] TAGW = 32'h2015_0008;
    localparam logic [31:0] DATW = 32'h2015_0408;
    localparam logic [31:0] BEHRW = 32'h2015_0800;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    ccd_pkg::ccd_ipr_req_t internal_proc_reg = '0;
    ccd_pkg::ccd_acc_t io = '0;
    ccd_pkg::ccd_acc_t lk = '0;
    ccd_pkg::ccd_fill_t fill = '0;
    logic ipr_ack_o, io_pass_o, io_ack_o, lk_ready_o, lk_done_o, lk_hit_o, lk_tag_perr_o, lk_data_perr_o;
    logic [31:0] ipr_rdata_o, io_rdata_o, lk_rdata_o;
    logic [2:0] repl_ptr_o;
    logic [31:0] seed = 32'h3e;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] ipr_q[$];
    logic [31:0] io_q[$];
    logic [35:0] lk_q[$];
    logic diag = 1'b0;
    logic [31:0] d1, d2, t, wv, f0, f1, a2, la;
    logic [7:0] bx;

    always #2.5 clock_i = ~clock_i;

    ccd_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .ipr_i(internal_proc_reg), .ipr_ack_o(ipr_ack_o),
        .ipr_rdata_o(ipr_rdata_o), .io_i(io), .io_pass_o(io_pass_o), .io_ack_o(io_ack_o),
        .io_rdata_o(io_rdata_o), .lk_i(lk), .lk_ready_o(lk_ready_o), .lk_done_o(lk_done_o),
        .lk_hit_o(lk_hit_o), .lk_rdata_o(lk_rdata_o), .lk_tag_perr_o(lk_tag_perr_o),
        .lk_data_perr_o(lk_data_perr_o), .fill_i(fill), .repl_ptr_o(repl_ptr_o));

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Even parity on even byte lanes, odd parity on odd lanes
    function automatic logic [3:0] par4(input logic [31:0] d);
        logic [3:0] p;
        for (int i = 0; i < 4; i++)
            p[i] = (^d[i*8 +: 8]) ^ (i % 2 == 1);
        return p;
    endfunction : par4

    function automatic logic [31:0] tagword(input logic [31:0] tg, input logic [3:0] dp, input logic v);
        return {3'h0, tg[18:0], 2'h0, dp, 2'h0, ~(^tg[18:0]), v};
    endfunction : tagword

    task automatic tally_and_finish();
        $display("TB: errors=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic cmp32(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp32

    // Bit 35 of a lookup note says whether read data is compared
    task automatic cmp_lk(input logic [35:0] exp);
        logic [35:0] got;
        got = {exp[35], lk_hit_o, lk_tag_perr_o, lk_data_perr_o, exp[35] ? lk_rdata_o : exp[31:0]};
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_lk

    task automatic ipr_acc(input logic wr, input logic [31:0] wd, input logic [31:0] exp);
        @(posedge clock_i);
        internal_proc_reg <= '{wr:wr, rd:~wr, num:8'h25, wdata:wd};
        if (!wr)
            ipr_q.push_back(exp);
        if (wr)
            diag = wd[0];
        @(posedge clock_i);
        internal_proc_reg <= '0;
    endtask : ipr_acc

    task automatic io_acc(input logic wr, input logic [31:0] a, input logic [3:0] be, input logic [31:0] wd,
        input logic [31:0] exp);
        @(posedge clock_i);
        io <= '{req:1'b1, wr:wr, dstream:1'b1, be:be, addr:a, wdata:wd};
        #1;
        cmp32({31'h0, ~diag}, {31'h0, io_pass_o});
        cmp32({31'h0, ~diag}, {31'h0, lk_ready_o});
        // Window writes are acknowledged too, with zero data
        if (diag)
            io_q.push_back(wr ? 32'h0 : exp);
        @(posedge clock_i);
        io <= '0;
    endtask : io_acc

    task automatic look(input logic [31:0] a, input logic [35:0] exp);
        @(posedge clock_i);
        lk <= '{req:1'b1, wr:1'b0, dstream:1'b1, be:4'hf, addr:a, wdata:32'h0};
        lk_q.push_back(exp);
        @(posedge clock_i);
        lk <= '0;
    endtask : look

    task automatic fill_pair(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        @(posedge clock_i);
        fill <= '{valid:1'b1, addr:a, data:lo};
        @(posedge clock_i);
        fill <= '{valid:1'b1, addr:a | 32'h4, data:hi};
        @(posedge clock_i);
        fill <= '0;
    endtask : fill_pair

    task automatic chk_ptr(input logic [2:0] e);
        @(posedge clock_i);
        #1;
        cmp32({29'h0, e}, {29'h0, repl_ptr_o});
    endtask : chk_ptr

    // Result watcher: takes the oldest note whenever an answer appears
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            tally_and_finish();
        end
        if (ipr_ack_o === 1'b1)
            cmp32(ipr_q.size() > 0 ? ipr_q.pop_front() : ~ipr_rdata_o, ipr_rdata_o);
        if (io_ack_o === 1'b1)
            cmp32(io_q.size() > 0 ? io_q.pop_front() : ~io_rdata_o, io_rdata_o);
        if (lk_done_o === 1'b1)
            cmp_lk(lk_q.size() > 0 ? lk_q.pop_front() : 36'hf_ffff_ffff);
    end

    initial
    begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        chk_ptr(3'h0);
        ipr_acc(1'b0, 32'h0, 32'h10);
        wv = xs();
        ipr_acc(1'b1, wv, 32'h0);
        ipr_acc(1'b0, 32'h0, {27'h0, 1'b1, wv[3:2], 1'b0, wv[0]});
        ipr_acc(1'b1, 32'hffff_ffe0, 32'h0);
        ipr_acc(1'b0, 32'h0, 32'h10);
        io_acc(1'b0, BEHRW, 4'hf, 32'h0, 32'h0);
        ipr_acc(1'b1, 32'h1, 32'h0);
        io_acc(1'b1, 32'h2015_0ff0, 4'hf, 32'h2, 32'h0);
        io_acc(1'b0, 32'h2015_0804, 4'hf, 32'h0, 32'h2);
        d1 = xs();
        d2 = xs();
        bx = 8'(xs());
        io_acc(1'b1, DATW, 4'hf, d1, 32'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h4, 32'h0);
        io_acc(1'b1, DATW, 4'hf, d2, 32'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h6, 32'h0);
        io_acc(1'b0, DATW, 4'hf, 32'h0, d1);
        io_acc(1'b1, DATW, 4'h2, {16'h0, bx, 8'h0}, 32'h0);
        d1[15:8] = bx;
        d2[15:8] = bx;
        io_acc(1'b0, DATW, 4'hf, 32'h0, d1);
        t = xs();
        io_acc(1'b1, TAGW, 4'hf, tagword(t, 4'h0, 1'b1), 32'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h4, 32'h0);
        io_acc(1'b0, DATW, 4'hf, 32'h0, d2);
        io_acc(1'b0, TAGW, 4'hf, 32'h0, tagword(t, par4(d2), 1'b1));
        ipr_acc(1'b1, 32'h9, 32'h0);
        io_acc(1'b0, TAGW, 4'hf, 32'h0, tagword(t, ~par4(d2), 1'b1));
        io_acc(1'b1, BEHRW, 4'hf, 32'h6, 32'h0);
        la = {3'h0, t[18:0], 7'h1, 3'h0};
        look(la, 36'h0);
        ipr_acc(1'b1, 32'hd, 32'h0);
        look(la, {4'b1101, d1});
        io_acc(1'b0, BEHRW, 4'hf, 32'h0, 32'h0000_0606);
        ipr_acc(1'b1, 32'h5, 32'h0);
        look(la, {4'b1100, d1});
        ipr_acc(1'b1, 32'h7, 32'h0);
        ipr_acc(1'b0, 32'h0, 32'h15);
        look(la, 36'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h1, 32'h0);
        f0 = xs();
        f1 = xs();
        t = xs();
        a2 = {3'h0, t[18:0], 7'h5, 3'h0};
        fill_pair(a2, f0, f1);
        chk_ptr(3'h1);
        look(a2 | 32'h4, {4'b1100, f1});
        look(a2, {4'b1100, f0});
        ipr_acc(1'b1, 32'h1, 32'h0);
        chk_ptr(3'h0);
        look(a2, 36'h0);
        ipr_acc(1'b1, 32'h5, 32'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h0, 32'h0);
        look(a2, 36'h0);
        io_acc(1'b1, BEHRW, 4'hf, 32'h1, 32'h0);
        look(a2, {4'b1100, f0});
        repeat (4) @(posedge clock_i);
        cmp32(32'h0, 32'(ipr_q.size() + io_q.size() + lk_q.size()));
        tally_and_finish();
    end
endmodule : test_cache_control_diag_access
